/* bcl_pkg.sv */
// package: command codes, bank states and timing constants for the bank legality block
package bcl_pkg;
	// command codes on the command bus
	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_ACT,
		CMD_RD,
		CMD_WR,
		CMD_PRE,
		CMD_PREA,
		CMD_REF,
		CMD_MRR,
		CMD_MRW,
		CMD_RST,
		CMD_BST
	} bcl_cmd_t;
	// per-bank state as seen by the tracker
	typedef enum logic [3:0] {
		ST_POWER_ON,
		ST_RESETTING,
		ST_IDLE,
		ST_ACTIVATING,
		ST_ACTIVE,
		ST_READING,
		ST_WRITING,
		ST_RD_AP,
		ST_WR_AP,
		ST_PRECHARGING,
		ST_REFRESHING,
		ST_MR_READING,
		ST_MR_WRITING
	} bcl_state_t;
	// clock period in ps (40 MHz)
	localparam int CLK_PS = 25000;
	// timing figures in ps
	localparam int T_RCD_PS = 18000;
	localparam int T_RP_PS = 18000;
	localparam int T_RRD_PS = 10000;
	localparam int T_RFCAB_PS = 130000;
	// timing figures in clock cycles
	localparam int T_MRR_CK = 2;
	localparam int T_MRW_CK = 5;
	localparam int T_BURST_CK = 4;
	// least times round up to whole cycles, never below one
	function automatic int cyc_up(input int ps);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RCD_CYC = cyc_up(T_RCD_PS);
	localparam int RP_CYC = cyc_up(T_RP_PS);
	localparam int RRD_CYC = cyc_up(T_RRD_PS);
	localparam int RFC_CYC = cyc_up(T_RFCAB_PS);
	localparam int TMR_W = 8;
endpackage

/* bcl_if.sv */
// interface: command bus between controller and memory device
`timescale 1ns/1ps
interface bcl_if #(parameter int BANKS = 8, parameter int DW = 16);
	logic cke;
	logic [3:0] cmd;
	logic [$clog2(BANKS)-1:0] bank;
	logic ap;
	logic [DW-1:0] wdata;
	logic dm;
	logic wvalid;
	// controller side
	modport ctrl (output cke, cmd, bank, ap, wdata, dm, wvalid);
	// device side
	modport dev (input cke, cmd, bank, ap, wdata, dm, wvalid);
endinterface

/* bcl_bank.sv */
// one bank: state and its timer
`timescale 1ns/1ps
module bcl_bank (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// command for this bank
	input wire logic go_i,
	input wire bcl_pkg::bcl_state_t nxt_i,
	input wire logic [bcl_pkg::TMR_W-1:0] cnt_i,
	input wire bcl_pkg::bcl_state_t ret_i,
	input wire logic bst_i,
	// state out
	output bcl_pkg::bcl_state_t st_o,
	output logic busy_o
);
	bcl_pkg::bcl_state_t st_r;
	bcl_pkg::bcl_state_t ret_r; // state after timed phase
	logic [bcl_pkg::TMR_W-1:0] tmr_r; // cycles left in timed phase

	// state and timer update
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r <= bcl_pkg::ST_POWER_ON;
			ret_r <= bcl_pkg::ST_POWER_ON;
			tmr_r <= '0;
		end
		else if (go_i)
		begin
			st_r <= nxt_i;
			ret_r <= ret_i;
			tmr_r <= cnt_i;
		end
		else if (bst_i)
		begin
			st_r <= bcl_pkg::ST_ACTIVE;
			tmr_r <= '0;
		end
		else if (tmr_r > 8'h01)
			tmr_r <= tmr_r - 8'h01;
		else if (tmr_r == 8'h01)
		begin
			tmr_r <= '0;
			st_r <= ret_r;
		end
		// auto-initialisation finishes once no mode read holds the bank
		else if (st_r == bcl_pkg::ST_RESETTING)
			st_r <= bcl_pkg::ST_IDLE;
	end
	assign st_o = st_r;
	assign busy_o = (tmr_r != '0);
endmodule

/* bcl_dev.sv */
// device end: tracks bank states and checks command legality
// How it works
// - all-bank refresh holds device for tRFCab
// - MR read lasts tMRR, returns prior or settled state
// - MR write lasts tMRW, then Idle
// - precharge all uninterruptible until tRP
// - refresh/MRW only with all idle
// - reset via MRW moves to Resetting
// - nothing but NOP or in-burst BST to AP bank
// - write after read needs end/BST
// - read after write needs end/BST
// - BST ends latest burst, bank Active
// - BST only while burst ongoing
// - BST not aimed at other bank
// - precharge of idle bank costs tRP
// - tRRD between activates
// - MRR allowed during activating/precharging
// - other banks usable during bursts
// - Idle after tRP, Active after tRCD
// - precharge all needs legal bank states
// - act only with CKE high twice
// - unlisted sequences are illegal
// - data mask high blocks write beat
// - AP burst allows other-bank commands
// - busy banks take only NOP, BST, or MRR when activating/precharging
`timescale 1ns/1ps
module bcl_dev #(
	parameter int BANKS = 8,
	parameter int DW = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// command bus
	bcl_if.dev bus,
	// user side: accepted write beats and status
	output logic wr_en_o,
	output logic [DW-1:0] wr_data_o,
	output logic [$clog2(BANKS)-1:0] wr_bank_o,
	output logic illegal_o,
	output logic all_idle_o
);
	localparam int BW = $clog2(BANKS);
	bcl_pkg::bcl_state_t st [BANKS]; // bank states
	logic [BANKS-1:0] busy; // bank in a timed phase
	logic [BANKS-1:0] go; // load per bank
	bcl_pkg::bcl_state_t nxt; // next state of loaded banks
	bcl_pkg::bcl_state_t ret; // state after the phase
	logic [bcl_pkg::TMR_W-1:0] cnt; // phase length
	logic [BANKS-1:0] bst_hit; // bank stopped by BST
	logic cke_q_r; // CKE at the previous edge
	logic [bcl_pkg::TMR_W-1:0] rrd_r; // tRRD cycles left to block
	logic [BW-1:0] last_bank_r; // bank of latest burst
	logic burst_on_r; // a burst is running
	logic [bcl_pkg::TMR_W-1:0] bcnt_r; // burst cycles left
	logic ill; // command illegal this cycle
	logic all_idle;
	logic live; // command is evaluated
	bcl_pkg::bcl_state_t cur; // state of addressed bank
	logic wr_en_r;
	logic [DW-1:0] wr_data_r;
	logic [BW-1:0] wr_bank_r;
	logic ill_r;
	logic all_idle_r;

	// one tracker per bank
	for (genvar g = 0; g < BANKS; g++)
	begin : g_bank
		bcl_bank u_bank (
			.clk_sys_i(clk_sys_i),
			.nrst_i(nrst_i),
			.go_i(go[g]),
			.nxt_i(nxt),
			.cnt_i(cnt),
			.ret_i(ret),
			.bst_i(bst_hit[g]),
			.st_o(st[g]),
			.busy_o(busy[g])
		);
	end

	// any bank in a device-wide hold
	function automatic logic dev_hold(input bcl_pkg::bcl_state_t s);
		return s == bcl_pkg::ST_REFRESHING || s == bcl_pkg::ST_MR_WRITING
			|| s == bcl_pkg::ST_MR_READING;
	endfunction

	// commands take effect only with CKE high now and before
	assign live = bus.cke && cke_q_r;
	assign cur = st[bus.bank];

	// idle summary
	always_comb
	begin
		all_idle = !burst_on_r;
		for (int i = 0; i < BANKS; i++)
			if (st[i] != bcl_pkg::ST_IDLE)
				all_idle = 1'b0;
	end

	// legality and next-state decode
	always_comb
	begin
		bcl_pkg::bcl_cmd_t c;
		logic hold;
		c = bcl_pkg::bcl_cmd_t'(bus.cmd);
		hold = 1'b0;
		for (int i = 0; i < BANKS; i++)
			if (dev_hold(st[i]) || (st[i] == bcl_pkg::ST_PRECHARGING && busy == '1))
				hold = 1'b1;
		go = '0;
		nxt = cur;
		ret = cur;
		cnt = '0;
		bst_hit = '0;
		ill = 1'b0;
		if (live && c != bcl_pkg::CMD_NOP)
		begin
			if (hold)
				ill = 1'b1;
			else
				case (c)
					bcl_pkg::CMD_ACT:
					begin
						// activate: idle bank, tRRD kept
						ill = cur != bcl_pkg::ST_IDLE || busy[bus.bank]
							|| rrd_r != '0;
						go[bus.bank] = !ill;
						nxt = bcl_pkg::ST_ACTIVATING;
						ret = bcl_pkg::ST_ACTIVE;
						cnt = bcl_pkg::TMR_W'(bcl_pkg::RCD_CYC);
					end
					bcl_pkg::CMD_RD, bcl_pkg::CMD_WR:
					begin
						// bursts only to active banks (bursting banks are busy); others unaffected
						ill = busy[bus.bank] || !(cur == bcl_pkg::ST_ACTIVE
							|| cur == bcl_pkg::ST_READING
							|| cur == bcl_pkg::ST_WRITING);
						// read/write turn-around needs the old burst ended
						if (burst_on_r && last_bank_r == bus.bank
							&& ((c == bcl_pkg::CMD_WR) != (cur == bcl_pkg::ST_WRITING)))
							ill = 1'b1;
						go[bus.bank] = !ill;
						if (bus.ap)
						begin
							nxt = (c == bcl_pkg::CMD_RD) ? bcl_pkg::ST_RD_AP
								: bcl_pkg::ST_WR_AP;
							ret = bcl_pkg::ST_IDLE;
							cnt = bcl_pkg::TMR_W'(bcl_pkg::T_BURST_CK + bcl_pkg::RP_CYC);
						end
						else
						begin
							nxt = (c == bcl_pkg::CMD_RD) ? bcl_pkg::ST_READING
								: bcl_pkg::ST_WRITING;
							ret = bcl_pkg::ST_ACTIVE;
							cnt = bcl_pkg::TMR_W'(bcl_pkg::T_BURST_CK);
						end
					end
					bcl_pkg::CMD_PRE:
					begin
						// idle bank still pays tRP
						ill = busy[bus.bank] || !(cur == bcl_pkg::ST_IDLE
							|| cur == bcl_pkg::ST_ACTIVE);
						go[bus.bank] = !ill;
						nxt = bcl_pkg::ST_PRECHARGING;
						ret = bcl_pkg::ST_IDLE;
						cnt = bcl_pkg::TMR_W'(bcl_pkg::RP_CYC);
					end
					bcl_pkg::CMD_PREA:
					begin
						// every bank must be idle or active
						for (int i = 0; i < BANKS; i++)
							if (busy[i] || !(st[i] == bcl_pkg::ST_IDLE
								|| st[i] == bcl_pkg::ST_ACTIVE))
								ill = 1'b1;
						go = ill ? '0 : '1;
						nxt = bcl_pkg::ST_PRECHARGING;
						ret = bcl_pkg::ST_IDLE;
						cnt = bcl_pkg::TMR_W'(bcl_pkg::RP_CYC);
					end
					bcl_pkg::CMD_REF, bcl_pkg::CMD_MRW:
					begin
						ill = !all_idle;
						go = ill ? '0 : '1;
						nxt = (c == bcl_pkg::CMD_REF) ? bcl_pkg::ST_REFRESHING
							: bcl_pkg::ST_MR_WRITING;
						ret = bcl_pkg::ST_IDLE;
						cnt = (c == bcl_pkg::CMD_REF) ? bcl_pkg::TMR_W'(bcl_pkg::RFC_CYC)
							: bcl_pkg::TMR_W'(bcl_pkg::T_MRW_CK);
					end
					bcl_pkg::CMD_RST:
					begin
						// reset through MRW: from Power On (or idle) to Resetting
						ill = !(st[0] == bcl_pkg::ST_POWER_ON || all_idle);
						go = ill ? '0 : '1;
						nxt = bcl_pkg::ST_RESETTING;
						ret = bcl_pkg::ST_RESETTING;
						cnt = '0;
					end
					bcl_pkg::CMD_MRR:
					begin
						// bank returns to its stable state after tMRR
						ill = !(cur == bcl_pkg::ST_IDLE || cur == bcl_pkg::ST_ACTIVE
							|| cur == bcl_pkg::ST_RESETTING
							|| cur == bcl_pkg::ST_ACTIVATING
							|| cur == bcl_pkg::ST_PRECHARGING);
						go[bus.bank] = !ill;
						nxt = bcl_pkg::ST_MR_READING;
						ret = (cur == bcl_pkg::ST_ACTIVATING) ? bcl_pkg::ST_ACTIVE
							: (cur == bcl_pkg::ST_PRECHARGING) ? bcl_pkg::ST_IDLE : cur;
						cnt = bcl_pkg::TMR_W'(bcl_pkg::T_MRR_CK);
					end
					bcl_pkg::CMD_BST:
					begin
						// stops the latest burst, only when aimed at its bank
						ill = !burst_on_r || last_bank_r != bus.bank;
						if (!ill)
							bst_hit[last_bank_r] = 1'b1;
					end
					default: ill = 1'b1;
				endcase
		end
	end

	// previous CKE
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cke_q_r <= 1'b0;
		else
			cke_q_r <= bus.cke;
	end

	// tRRD counter restarts on each accepted activate
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rrd_r <= '0;
		else if (go != '0 && nxt == bcl_pkg::ST_ACTIVATING)
			// the next edge is already one cycle on, so one count less blocks
			rrd_r <= bcl_pkg::TMR_W'(bcl_pkg::RRD_CYC - 1);
		else if (rrd_r != '0)
			rrd_r <= rrd_r - 8'h01;
	end

	// latest burst tracking
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			burst_on_r <= 1'b0;
			last_bank_r <= '0;
			bcnt_r <= '0;
		end
		else if (go != '0 && (nxt == bcl_pkg::ST_READING || nxt == bcl_pkg::ST_WRITING
			|| nxt == bcl_pkg::ST_RD_AP || nxt == bcl_pkg::ST_WR_AP))
		begin
			burst_on_r <= 1'b1;
			last_bank_r <= bus.bank;
			bcnt_r <= bcl_pkg::TMR_W'(bcl_pkg::T_BURST_CK);
		end
		else if (bst_hit != '0 || bcnt_r == 8'h01)
		begin
			burst_on_r <= 1'b0;
			bcnt_r <= '0;
		end
		else if (bcnt_r != '0)
			bcnt_r <= bcnt_r - 8'h01;
	end

	// write beats: mask high drops the beat
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_en_r <= 1'b0;
			wr_data_r <= '0;
			wr_bank_r <= '0;
		end
		else
		begin
			wr_en_r <= bus.wvalid && !bus.dm && burst_on_r;
			wr_data_r <= bus.wdata;
			wr_bank_r <= last_bank_r;
		end
	end

	// status flops
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ill_r <= 1'b0;
			all_idle_r <= 1'b0;
		end
		else
		begin
			ill_r <= ill;
			all_idle_r <= all_idle;
		end
	end
	assign wr_en_o = wr_en_r;
	assign wr_data_o = wr_data_r;
	assign wr_bank_o = wr_bank_r;
	assign illegal_o = ill_r;
	assign all_idle_o = all_idle_r;
endmodule

/* bcl_ctrl.sv */
// controller end: registers user commands onto the bus, NOP when idle
`timescale 1ns/1ps
module bcl_ctrl #(
	parameter int BANKS = 8,
	parameter int DW = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// user request
	input wire logic req_i,
	input wire logic [3:0] cmd_i,
	input wire logic [$clog2(BANKS)-1:0] bank_i,
	input wire logic ap_i,
	input wire logic cke_i,
	input wire logic wvalid_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic dm_i,
	// command bus
	bcl_if.ctrl bus
);
	// drive bus from flops; NOP unless requested
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bus.cke <= 1'b0;
			bus.cmd <= bcl_pkg::CMD_NOP;
			bus.bank <= '0;
			bus.ap <= 1'b0;
			bus.wdata <= '0;
			bus.dm <= 1'b1;
			bus.wvalid <= 1'b0;
		end
		else
		begin
			bus.cke <= cke_i;
			bus.cmd <= req_i ? cmd_i : bcl_pkg::CMD_NOP;
			bus.bank <= bank_i;
			bus.ap <= ap_i;
			bus.wdata <= wdata_i;
			bus.dm <= dm_i;
			bus.wvalid <= wvalid_i;
		end
	end
endmodule

/* bcl_properties.sv */
// checker: timing relations on the command bus and device outputs
`timescale 1ns/1ps
module bcl_properties #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// bus signals
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic [DW-1:0] wdata,
	input wire logic dm,
	input wire logic wvalid,
	// device outputs
	input wire logic wr_en_o,
	input wire logic [DW-1:0] wr_data_o,
	input wire logic illegal_o,
	input wire logic all_idle_o
);
	logic cke_r; // clock enable at the previous edge
	// remember clock enable for the two-edge qualifier
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cke_r <= 1'b0;
		else
			cke_r <= cke;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// device-wide command taken from all idle, then a non-nop at once
	sequence s_hold(logic [3:0] c);
		cmd == c && all_idle_o && cke && cke_r ##1 cmd != bcl_pkg::CMD_NOP && cke;
	endsequence
	a_refresh_quiet: assert property (s_hold(bcl_pkg::CMD_REF) |=> illegal_o)
		else $error("command during refresh accepted");
	a_mrr_quiet: assert property (s_hold(bcl_pkg::CMD_MRR) |=> illegal_o)
		else $error("command during mode read accepted");
	a_mrw_quiet: assert property (s_hold(bcl_pkg::CMD_MRW) |=> illegal_o)
		else $error("command during mode write accepted");
	a_prea_quiet: assert property (s_hold(bcl_pkg::CMD_PREA) |=> illegal_o)
		else $error("command during precharge all accepted");
	a_needs_all_idle: assert property ((cmd == bcl_pkg::CMD_REF || cmd == bcl_pkg::CMD_MRW)
		&& !all_idle_o && cke && cke_r |=> illegal_o)
		else $error("device-wide command accepted while busy");
	a_cke_gates_eval: assert property (!(cke && cke_r) |=> !illegal_o && !wr_en_o)
		else $error("command evaluated without clock enable");
	a_nop_always_legal: assert property (cmd == bcl_pkg::CMD_NOP |=> !illegal_o)
		else $error("nop refused");
	a_mask_blocks: assert property (wr_en_o |-> $past(wvalid && !dm && cke))
		else $error("masked or absent beat written");
	a_beat_data: assert property (wr_en_o |-> wr_data_o == $past(wdata))
		else $error("written beat data differs");
endmodule

/* bank_command_legality_fsm_bench.sv */
// testbench: controller and device joined, command sequences with expected refusals
`timescale 1ns/1ps
module bank_command_legality_fsm_bench;
	logic clk_sys_i = 1'b0; // system clock
	logic nrst_i = 1'b0; // reset, active low
	logic req_i = 1'b0; // user request inputs
	logic [3:0] cmd_i = 4'h0;
	logic [2:0] bank_i = 3'h0;
	logic ap_i = 1'b0;
	logic cke_i = 1'b0;
	logic wvalid_i = 1'b0;
	logic [15:0] wdata_i = 16'h0000;
	logic dm_i = 1'b0;
	logic wr_en_o; // device outputs
	logic [15:0] wr_data_o;
	logic [2:0] wr_bank_o;
	logic illegal_o;
	logic all_idle_o;
	logic pv_e = 1'b0; // expectations of the previous cycle
	logic pv_w = 1'b0;
	logic [15:0] pv_d = 16'h0000;
	int n_fail = 0;
	int checks = 0;
	int i;
	// clock at 40 MHz
	always #12.5 clk_sys_i = ~clk_sys_i;
	bcl_if bus_if ();
	bcl_ctrl #(.BANKS(8), .DW(16)) bcl_ctrl_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.req_i(req_i), .cmd_i(cmd_i), .bank_i(bank_i), .ap_i(ap_i), .cke_i(cke_i),
		.wvalid_i(wvalid_i), .wdata_i(wdata_i), .dm_i(dm_i), .bus(bus_if));
	bcl_dev #(.BANKS(8), .DW(16)) bcl_dev_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.bus(bus_if), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o), .wr_bank_o(wr_bank_o),
		.illegal_o(illegal_o), .all_idle_o(all_idle_o));
	bcl_properties bcl_properties_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.cke(bus_if.cke), .cmd(bus_if.cmd), .wdata(bus_if.wdata), .dm(bus_if.dm),
		.wvalid(bus_if.wvalid), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o),
		.illegal_o(illegal_o), .all_idle_o(all_idle_o));
	// verdict and end of run
	task conclude();
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one cycle: drive a command and beat, judge the one sent a cycle before
	task go(input bcl_pkg::bcl_cmd_t c, input logic [2:0] b, input logic a, input logic e,
		input logic v = 1'b0, input logic m = 1'b0, input logic [15:0] d = 16'h0000);
		req_i = (c != bcl_pkg::CMD_NOP);
		cmd_i = c;
		bank_i = b;
		ap_i = a;
		wvalid_i = v;
		dm_i = m;
		wdata_i = d;
		@(negedge clk_sys_i);
		chk({15'h0000, illegal_o}, {15'h0000, pv_e});
		chk({15'h0000, wr_en_o}, {15'h0000, pv_w});
		if (pv_w)
			chk(wr_data_o, pv_d);
		// the only unmasked beat of the sequence belongs to the write burst on bank 0
		if (pv_w)
			chk({13'h0000, wr_bank_o}, 16'h0000);
		pv_e = e;
		pv_w = v && !m;
		pv_d = d;
	endtask
	// idle cycles
	task nop(input int k);
		repeat (k) go(bcl_pkg::CMD_NOP, 3'h0, 1'b0, 1'b0);
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		go(bcl_pkg::CMD_BST, 3'h0, 1'b0, 1'b0);
		cke_i = 1'b1;
		go(bcl_pkg::CMD_BST, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h0, 1'b0, 1'b1);
		go(bcl_pkg::CMD_RST, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_MRR, 3'h0, 1'b0, 1'b0);
		i = 0;
		while (all_idle_o !== 1'b1 && i < 300)
		begin
			nop(1);
			i++;
		end
		if (i == 300)
		begin
			n_fail++;
			conclude();
		end
		go(bcl_pkg::CMD_REF, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h0, 1'b0, 1'b1);
		nop(6);
		go(bcl_pkg::CMD_ACT, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h1, 1'b0, 1'b0);
		go(bcl_pkg::CMD_REF, 3'h0, 1'b0, 1'b1);
		go(bcl_pkg::CMD_RD, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_WR, 3'h0, 1'b0, 1'b1);
		go(bcl_pkg::CMD_BST, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_WR, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_RD, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 16'hA5C3);
		go(bcl_pkg::CMD_BST, 3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 16'h5A3C);
		nop(6);
		go(bcl_pkg::CMD_BST, 3'h0, 1'b0, 1'b1);
		go(bcl_pkg::CMD_RD, 3'h1, 1'b1, 1'b0);
		go(bcl_pkg::CMD_PRE, 3'h1, 1'b0, 1'b1);
		go(bcl_pkg::CMD_PRE, 3'h0, 1'b0, 1'b0);
		nop(8);
		chk({15'h0000, all_idle_o}, 16'h0001);
		go(bcl_pkg::CMD_MRW, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h0, 1'b0, 1'b1);
		nop(5);
		go(bcl_pkg::CMD_PREA, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h0, 1'b0, 1'b1);
		nop(2);
		go(bcl_pkg::CMD_PRE, 3'h2, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h2, 1'b0, 1'b1);
		nop(2);
		go(bcl_pkg::CMD_MRR, 3'h0, 1'b0, 1'b0);
		go(bcl_pkg::CMD_ACT, 3'h0, 1'b0, 1'b1);
		nop(3);
		conclude();
	end
endmodule
